/* File: rtl/fpi_top.v */
// Functional notes
// - Command interrupt is done flag AND its enable.
// - Error interrupt: double fault and enable, or single fault and enable.
// - ECC double and single errors on reads set separate fault flags.
// - Flash guard register loads from byte 0x040D during reset sequence.
// - Low range grows up from 0x0000, high down from 0x7FFF, rest third.
// - Open=1: zero disable protects range; open=0: all but those ranges.
// - High size 00..11 gives 1, 2, 4, 8 KB ending at 0x7FFF.
// - Low size 00..11 gives 2, 4, 8, 16 KB starting at zero.
// - Writes making a disallowed scenario transition are ignored.
// - Allowed scenario transitions follow the fixed transition table.
// - Guard register reads the scenario in force; rejected writes keep it.
// - EEPROM open bit and size load from byte 0x040C at reset.
// - EEPROM size code n protects 32*(n+1) bytes from address zero.
// - Config field: key, reserved, EEPROM, flash, security, option bytes.
// - Done flag is clear while a command runs, set when it finishes.
`timescale 1ns/100ps
`include "fpi_map.vh"

module fpi_top (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// Nonvolatile byte fetch during reset sequence
	output reg nvm_rd,
	output reg [15:0] nvm_addr,
	input wire nvm_rvalid,
	input wire [7:0] nvm_rdata,
	// Command controller
	input wire cmd_pgm_erase,
	input wire cmd_eeprom,
	input wire [15:0] cmd_addr,
	output reg cmd_start,
	input wire cmd_finish,
	// ECC events from the read path
	input wire ecc_single,
	input wire ecc_double,
	// Interrupt requests
	output wire cmd_irq,
	output wire err_irq
);

	localparam S_LDE = 3'b001;
	localparam S_LDF = 3'b010;
	localparam S_RUN = 3'b100;
	localparam [7:0] FG_RST = `FPI_RST_FLASH_GUARD;
	localparam [7:0] EG_RST = `FPI_RST_EEPROM_GUARD;

	reg [1:0] rst_pipe;
	wire rst_int_n;
	reg [2:0] state;
	reg cmd_done_flag;
	reg guard_violation_flag;
	reg cmd_done_irq_en;
	reg double_fault_flag;
	reg single_fault_flag;
	reg double_fault_irq_en;
	reg single_fault_irq_en;
	reg flash_guard_open;
	reg high_range_disable;
	reg low_range_disable;
	reg [1:0] high_range_size;
	reg [1:0] low_range_size;
	reg eeprom_guard_open;
	reg [2:0] eeprom_guard_size;

	wire wr_en;
	wire setup;
	wire [7:0] wb;
	wire [7:0] flash_guard_reg;
	wire [7:0] eeprom_guard_reg;
	reg [7:0] next_rdata;
	reg next_err;
	wire launch;
	wire target_guarded;

	assign rst_int_n = rst_pipe[1];

	// Asserts at once, releases two edges later
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end

	// Scenario allowed from a source scenario to a target scenario
	function allowed;
		input [2:0] from;
		input [2:0] to;
		reg [7:0] mask;
		begin
			case (from)
			3'd0: mask = `FPI_TR_0;
			3'd1: mask = `FPI_TR_1;
			3'd2: mask = `FPI_TR_2;
			3'd3: mask = `FPI_TR_3;
			3'd4: mask = `FPI_TR_4;
			3'd5: mask = `FPI_TR_5;
			3'd6: mask = `FPI_TR_6;
			default: mask = `FPI_TR_7;
			endcase
			allowed = mask[to];
		end
	endfunction

	// Flash address covered by the active protection
	function flash_hit;
		input [15:0] a;
		input open;
		input hdis;
		input ldis;
		input [1:0] hs;
		input [1:0] ls;
		reg [15:0] hbase;
		reg [15:0] lend;
		reg in_h;
		reg in_l;
		begin
			hbase = `FPI_FLASH_TOP + 16'h0001 - (`FPI_HIGH_UNIT << hs);
			lend = (`FPI_LOW_UNIT << ls) - 16'h0001;
			in_h = !hdis && a >= hbase && a <= `FPI_FLASH_TOP;
			in_l = !ldis && a <= lend;
			// Outside both ranges is the third region
			if (open)
				flash_hit = in_h | in_l;
			else
				flash_hit = a <= `FPI_FLASH_TOP && !(in_h | in_l);
		end
	endfunction

	// EEPROM address covered by the protected block
	function eeprom_hit;
		input [15:0] a;
		input open;
		input [2:0] size;
		reg [8:0] span;
		begin
			span = {6'h00, size} * `FPI_EE_UNIT + `FPI_EE_UNIT;
			eeprom_hit = !open && a[15:8] == 8'h00 &&
				{1'b0, a[7:0]} < span;
		end
	endfunction

	assign flash_guard_reg = {flash_guard_open, 1'b0, high_range_disable,
		high_range_size, low_range_disable, low_range_size};
	assign eeprom_guard_reg = {eeprom_guard_open, 4'h0, eeprom_guard_size};

	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && !pslverr;
	assign wb = pwdata[7:0];

	// Launch only from idle with no violation pending
	assign launch = state == S_RUN && wr_en &&
		paddr == `FPI_OFS_CMD_STATUS && wb[`FPI_B_DONE] &&
		cmd_done_flag && !guard_violation_flag;

	assign target_guarded = cmd_pgm_erase && (cmd_eeprom ?
		eeprom_hit(cmd_addr, eeprom_guard_open, eeprom_guard_size) :
		flash_hit(cmd_addr, flash_guard_open, high_range_disable,
		low_range_disable, high_range_size, low_range_size));

	assign cmd_irq = cmd_done_flag && cmd_done_irq_en;
	assign err_irq = (double_fault_flag && double_fault_irq_en) ||
		(single_fault_flag && single_fault_irq_en);

	// Read data captured in setup so the access phase sees a flop
	always @* begin
		next_rdata = 8'h00;
		next_err = 1'b0;
		case (paddr)
		`FPI_OFS_CMD_STATUS: begin
			next_rdata[`FPI_B_DONE] = cmd_done_flag;
			next_rdata[`FPI_B_VIOL] = guard_violation_flag;
		end
		`FPI_OFS_CMD_CONFIG:
			next_rdata[`FPI_B_DONE] = cmd_done_irq_en;
		`FPI_OFS_ERR_STATUS: begin
			next_rdata[`FPI_B_DFLT] = double_fault_flag;
			next_rdata[`FPI_B_SFLT] = single_fault_flag;
		end
		`FPI_OFS_ERR_CONFIG: begin
			next_rdata[`FPI_B_DFLT] = double_fault_irq_en;
			next_rdata[`FPI_B_SFLT] = single_fault_irq_en;
		end
		`FPI_OFS_FLASH_GUARD:
			next_rdata = flash_guard_reg;
		`FPI_OFS_EEPROM_GUARD:
			next_rdata = eeprom_guard_reg;
		default:
			next_err = 1'b1;
		endcase
	end

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= {24'h000000, next_rdata};
			pslverr <= next_err;
		end
	end

	// Reset sequence fetches the two protection bytes in turn
	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			state <= S_LDE;
			nvm_rd <= 1'b1;
			nvm_addr <= `FPI_NV_EE_ADDR;
		end else begin
			case (state)
			S_LDE: if (nvm_rvalid) begin
				state <= S_LDF;
				nvm_addr <= `FPI_NV_FL_ADDR;
			end
			S_LDF: if (nvm_rvalid) begin
				state <= S_RUN;
				nvm_rd <= 1'b0;
				nvm_addr <= 16'h0000;
			end
			S_RUN: state <= S_RUN;
			default: begin
				state <= S_LDE;
				nvm_rd <= 1'b1;
				nvm_addr <= `FPI_NV_EE_ADDR;
			end
			endcase
		end
	end

	// Protection registers
	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			{flash_guard_open, high_range_disable, high_range_size,
				low_range_disable, low_range_size} <= {FG_RST[7], FG_RST[5:0]};
			{eeprom_guard_open, eeprom_guard_size} <= {EG_RST[7], EG_RST[2:0]};
		end else if (state == S_LDE && nvm_rvalid) begin
			eeprom_guard_open <= nvm_rdata[`FPI_B_OPEN];
			eeprom_guard_size <= nvm_rdata[2:0];
		end else if (state == S_LDF && nvm_rvalid) begin
			flash_guard_open <= nvm_rdata[`FPI_B_OPEN];
			high_range_disable <= nvm_rdata[`FPI_B_HDIS];
			high_range_size <= nvm_rdata[`FPI_B_HS+1:`FPI_B_HS];
			low_range_disable <= nvm_rdata[`FPI_B_LDIS];
			low_range_size <= nvm_rdata[`FPI_B_LS+1:`FPI_B_LS];
		end else if (state == S_RUN && wr_en) begin
			// Sizes move only while their range is disabled
			if (paddr == `FPI_OFS_FLASH_GUARD &&
				allowed({flash_guard_open, high_range_disable,
				low_range_disable}, {wb[`FPI_B_OPEN], wb[`FPI_B_HDIS],
				wb[`FPI_B_LDIS]}) &&
				(high_range_disable ||
				wb[`FPI_B_HS+1:`FPI_B_HS] == high_range_size) &&
				(low_range_disable ||
				wb[`FPI_B_LS+1:`FPI_B_LS] == low_range_size)) begin
				flash_guard_open <= wb[`FPI_B_OPEN];
				high_range_disable <= wb[`FPI_B_HDIS];
				high_range_size <= wb[`FPI_B_HS+1:`FPI_B_HS];
				low_range_disable <= wb[`FPI_B_LDIS];
				low_range_size <= wb[`FPI_B_LS+1:`FPI_B_LS];
			end
			// EEPROM guard may only close or grow
			if (paddr == `FPI_OFS_EEPROM_GUARD &&
				(eeprom_guard_open || !wb[`FPI_B_OPEN]) &&
				(eeprom_guard_open || wb[2:0] >= eeprom_guard_size))
			begin
				eeprom_guard_open <= wb[`FPI_B_OPEN];
				eeprom_guard_size <= wb[2:0];
			end
		end
	end

	// Command flags and enables
	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cmd_done_flag <= 1'b0;
			guard_violation_flag <= 1'b0;
			cmd_done_irq_en <= 1'b0;
			cmd_start <= 1'b0;
		end else begin
			cmd_start <= 1'b0;
			if (state == S_LDF && nvm_rvalid)
				cmd_done_flag <= 1'b1;
			if (wr_en && paddr == `FPI_OFS_CMD_CONFIG)
				cmd_done_irq_en <= wb[`FPI_B_DONE];
			if (wr_en && paddr == `FPI_OFS_CMD_STATUS &&
				wb[`FPI_B_VIOL])
				guard_violation_flag <= 1'b0;
			if (launch) begin
				if (target_guarded) begin
					guard_violation_flag <= 1'b1;
				end else begin
					cmd_done_flag <= 1'b0;
					cmd_start <= 1'b1;
				end
			end
			// Finish counts only while a command is running
			if (cmd_finish && !cmd_done_flag && state == S_RUN)
				cmd_done_flag <= 1'b1;
		end
	end

	// ECC fault flags; a new fault wins over a clear
	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			double_fault_flag <= 1'b0;
			single_fault_flag <= 1'b0;
			double_fault_irq_en <= 1'b0;
			single_fault_irq_en <= 1'b0;
		end else begin
			if (wr_en && paddr == `FPI_OFS_ERR_CONFIG) begin
				double_fault_irq_en <= wb[`FPI_B_DFLT];
				single_fault_irq_en <= wb[`FPI_B_SFLT];
			end
			if (ecc_double)
				double_fault_flag <= 1'b1;
			else if (wr_en && paddr == `FPI_OFS_ERR_STATUS &&
				wb[`FPI_B_DFLT])
				double_fault_flag <= 1'b0;
			if (ecc_single)
				single_fault_flag <= 1'b1;
			else if (wr_en && paddr == `FPI_OFS_ERR_STATUS &&
				wb[`FPI_B_SFLT])
				single_fault_flag <= 1'b0;
		end
	end

endmodule

/* File: rtl/fpi_map.vh */
`ifndef FPI_MAP_VH
`define FPI_MAP_VH

// Register byte offsets on the APB
`define FPI_OFS_CMD_STATUS 12'h000
`define FPI_OFS_CMD_CONFIG 12'h004
`define FPI_OFS_ERR_STATUS 12'h008
`define FPI_OFS_ERR_CONFIG 12'h00C
`define FPI_OFS_FLASH_GUARD 12'h010
`define FPI_OFS_EEPROM_GUARD 12'h014

// Field positions
`define FPI_B_DONE 7
`define FPI_B_VIOL 5
`define FPI_B_DFLT 1
`define FPI_B_SFLT 0
`define FPI_B_OPEN 7
`define FPI_B_HDIS 5
`define FPI_B_HS 3
`define FPI_B_LDIS 2
`define FPI_B_LS 0

// Reset values, held until the configuration bytes are loaded
`define FPI_RST_FLASH_GUARD 8'hFF
`define FPI_RST_EEPROM_GUARD 8'hFF

// Nonvolatile configuration field layout
`define FPI_NV_KEY_ADDR 16'h0400
`define FPI_NV_RSV_ADDR 16'h0408
`define FPI_NV_EE_ADDR 16'h040C
`define FPI_NV_FL_ADDR 16'h040D
`define FPI_NV_SEC_ADDR 16'h040E
`define FPI_NV_OPT_ADDR 16'h040F
`define FPI_NV_RSV_FILL 8'hFF

// Protection geometry
`define FPI_FLASH_TOP 16'h7FFF
`define FPI_HIGH_UNIT 16'h0400
`define FPI_LOW_UNIT 16'h0800
`define FPI_EE_UNIT 9'h020

// Allowed target scenarios, one bit per target, indexed by source
`define FPI_TR_0 8'h0F
`define FPI_TR_1 8'h0A
`define FPI_TR_2 8'h0C
`define FPI_TR_3 8'h08
`define FPI_TR_4 8'h18
`define FPI_TR_5 8'h3C
`define FPI_TR_6 8'h5A
`define FPI_TR_7 8'hFF

`endif

/* File: verif/fpi_chk.sv */
`timescale 1ns/100ps
module fpi_chk (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	// Far side
	input wire nvm_rd,
	input wire [15:0] nvm_addr,
	input wire nvm_rvalid,
	input wire cmd_start,
	input wire cmd_finish,
	input wire ecc_single,
	input wire ecc_double,
	input wire cmd_irq,
	input wire err_irq
);
	// Device waits two edges after release; one more edge of margin
	reg [2:0] rq;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rq <= 3'b000;
		else
			rq <= {rq[1:0], 1'b1};
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rq[2]);
	wire wr = psel & penable & pwrite;
	sequence s_go;
		wr && paddr == 12'h000 && pwdata[7];
	endsequence
	sequence s_nv(a);
		nvm_rd && nvm_rvalid && nvm_addr == a;
	endsequence
	property p_start;
		cmd_start |-> $past(wr && paddr == 12'h000 && pwdata[7]);
	endproperty
	property p_pulse;
		s_go ##1 cmd_start |=> !cmd_start;
	endproperty
	property p_run;
		s_go ##1 cmd_start |-> !cmd_irq;
	endproperty
	property p_irq;
		$rose(cmd_irq) |-> $past(cmd_finish || (wr && paddr == 12'h004));
	endproperty
	property p_err;
		$rose(err_irq) |-> $past(ecc_single || ecc_double ||
			(wr && paddr == 12'h00C));
	endproperty
	property p_nv1;
		s_nv(16'h040C) |=> nvm_rd && nvm_addr == 16'h040D;
	endproperty
	property p_nv2;
		s_nv(16'h040D) |=> !nvm_rd && nvm_addr == 16'h0000;
	endproperty
	property p_hold;
		nvm_rd && !nvm_rvalid |=> $stable(nvm_addr);
	endproperty
	a_start: assert property (p_start) else $error("stray start");
	a_pulse: assert property (p_pulse) else $error("start too long");
	a_run: assert property (p_run) else $error("irq while busy");
	a_irq: assert property (p_irq) else $error("cmd irq no cause");
	a_err: assert property (p_err) else $error("err irq no cause");
	a_nv1: assert property (p_nv1) else $error("bad 2nd fetch");
	a_nv2: assert property (p_nv2) else $error("fetch not ended");
	a_hold: assert property (p_hold) else $error("fetch addr moved");
endmodule
bind fpi_top fpi_chk u_chk (.*);

/* File: verif/fpi_far.sv */
`timescale 1ns/100ps
module fpi_far (
	// Nonvolatile fetch
	input wire clock,
	input wire nvm_rd,
	input wire [15:0] nvm_addr,
	input wire [7:0] ee_byte,
	input wire [7:0] fl_byte,
	output reg nvm_rvalid,
	output reg [7:0] nvm_rdata,
	// Command controller
	input wire cmd_start,
	output reg cmd_finish
);
	integer n = 0;
	integer w = 0;
	reg slow = 0;
	initial begin
		nvm_rvalid = 0;
		nvm_rdata = 8'h5A;
		cmd_finish = 0;
	end
	always @(posedge clock) begin
		nvm_rvalid <= 0;
		cmd_finish <= 0;
		// Toggling data so stale bytes never look valid
		nvm_rdata <= ~nvm_rdata;
		if (nvm_rd && !nvm_rvalid) begin
			n = n + 1;
			if (n > (slow ? 4 : 1)) begin
				n = 0;
				slow <= ~slow;
				nvm_rvalid <= 1;
				nvm_rdata <= nvm_addr == 16'h040C ? ee_byte :
					nvm_addr == 16'h040D ? fl_byte : 8'hFF;
			end
		end
		if (cmd_start) begin
			w = slow ? 6 : 2;
		end else if (w > 0) begin
			w = w - 1;
			if (w == 0) cmd_finish <= 1;
		end
	end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
	reg clock, rst_n, psel, penable, pwrite, ecc_single, ecc_double;
	reg cmd_pgm_erase, cmd_eeprom;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd, r, seed;
	reg [15:0] cmd_addr, a;
	reg [7:0] ee_b, fl_b;
	reg sl;
	wire pready, pslverr, nvm_rd, nvm_rvalid, cmd_start, cmd_finish;
	wire cmd_irq, err_irq;
	wire [31:0] prdata;
	wire [15:0] nvm_addr;
	wire [7:0] nvm_rdata;
	integer bad_count = 0;
	integer checks = 0;
	integer cyc = 0;
	integer i;
	fpi_top u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
		.nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata),
		.cmd_pgm_erase(cmd_pgm_erase), .cmd_eeprom(cmd_eeprom),
		.cmd_addr(cmd_addr), .cmd_start(cmd_start),
		.cmd_finish(cmd_finish), .ecc_single(ecc_single),
		.ecc_double(ecc_double), .cmd_irq(cmd_irq), .err_irq(err_irq));
	fpi_far u_far (.clock(clock), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
		.ee_byte(ee_b), .fl_byte(fl_b), .nvm_rvalid(nvm_rvalid),
		.nvm_rdata(nvm_rdata), .cmd_start(cmd_start),
		.cmd_finish(cmd_finish));
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	task finish_test;
		begin
			$display("checks %0d errors %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count = bad_count + 1;
			finish_test;
		end
	end
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			checks = checks + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("wrong value %s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task apb(input w, input [11:0] ad, input [31:0] d);
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= ad;
			pwdata <= d;
			@(posedge clock);
			penable <= 1;
			@(posedge clock);
			while (pready !== 1'b1) @(posedge clock);
			rd = prdata;
			sl = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge clock);
		end
	endtask
	task wdone;
		integer k;
		begin
			k = 0;
			rd = 0;
			while (rd[7] !== 1'b1 && k < 20) begin
				apb(0, 12'h000, 0);
				k = k + 1;
			end
			chk("done", 1, rd[7]);
		end
	endtask
	task rst(input [7:0] f, input [7:0] e);
		begin
			fl_b <= f;
			ee_b <= e;
			rst_n <= 0;
			repeat (3) @(posedge clock);
			rst_n <= 1;
			repeat (2) @(posedge clock);
			wdone;
			apb(0, 12'h010, 0);
			chk("fguard", f & 8'hBF, rd);
			apb(0, 12'h014, 0);
			chk("eguard", e & 8'h87, rd);
		end
	endtask
	task probe(input ee, input [15:0] ad, input p);
		begin
			cmd_eeprom <= ee;
			cmd_addr <= ad;
			cmd_pgm_erase <= 1;
			apb(1, 12'h000, 32'h80);
			apb(0, 12'h000, 0);
			chk("viol", p, rd[5]);
			chk("busy", p, rd[7]);
			if (p) apb(1, 12'h000, 32'h20);
			else wdone;
		end
	endtask
	task pulse(input [1:0] v);
		begin
			{ecc_double, ecc_single} <= v;
			@(posedge clock);
			{ecc_double, ecc_single} <= 2'b00;
			@(posedge clock);
		end
	endtask
	function [7:0] enc(input [2:0] s, input [1:0] h, input [1:0] l);
		enc = {s[2], 1'b0, s[1], h, s[0], l};
	endfunction
	function ok(input [2:0] f, input [2:0] t);
		reg [63:0] m;
		begin
			// One byte of allowed targets per source scenario
			m = 64'hFF5A3C18080C0A0F;
			ok = m[{f, t}];
		end
	endfunction
	initial begin
		{rst_n, psel, penable, pwrite, ecc_single, ecc_double} = 0;
		{cmd_pgm_erase, cmd_eeprom, paddr, pwdata, cmd_addr} = 0;
		{ee_b, fl_b} = 16'hFFFF;
		seed = 32'h1820;
		r = $random(seed);
		rst(r[7:0], r[15:8]);
		rst(8'hFF, 8'hFF);
		apb(0, 12'h018, 0);
		chk("slverr", 1, sl);
		chk("rdata", 0, rd);
		for (i = 0; i < 64; i = i + 1) begin
			r = $random(seed);
			rst(8'hFF, 8'hFF);
			apb(1, 12'h010, enc(i[5:3], r[1:0], r[3:2]));
			apb(1, 12'h010, enc(i[2:0], r[1:0], r[3:2]));
			apb(0, 12'h010, 0);
			chk("scen", enc(ok(i[5:3], i[2:0]) ? i[2:0] : i[5:3],
				r[1:0], r[3:2]), rd);
		end
		for (i = 0; i < 4; i = i + 1) begin
			a = 16'h8000 - (16'h0400 << i);
			rst(8'hFF, 8'hFF);
			apb(1, 12'h010, enc(5, i, 0));
			probe(0, a, 1);
			probe(0, a - 1, 0);
			rst(8'hFF, 8'hFF);
			apb(1, 12'h010, enc(1, i, 0));
			probe(0, a, 0);
			probe(0, a - 1, 1);
			a = 16'h0800 << i;
			rst(8'hFF, 8'hFF);
			apb(1, 12'h010, enc(6, 0, i));
			probe(0, a - 1, 1);
			probe(0, a, 0);
		end
		for (i = 0; i < 8; i = i + 1) begin
			rst(8'hFF, 8'hFF);
			apb(1, 12'h014, i);
			a = 32 * (i + 1);
			probe(1, a - 1, 1);
			probe(1, a, 0);
		end
		apb(1, 12'h00C, 3);
		for (i = 0; i < 2; i = i + 1) begin
			pulse(2'b10 >> i);
			chk("eirq", 1, err_irq);
			apb(0, 12'h008, 0);
			chk("eflag", 2'b10 >> i, rd);
			apb(1, 12'h008, 3);
			chk("eirq", 0, err_irq);
		end
		apb(1, 12'h00C, 0);
		pulse(2'b11);
		chk("eirq", 0, err_irq);
		apb(1, 12'h004, 32'h80);
		probe(0, 16'h4000, 0);
		chk("cirq", 1, cmd_irq);
		apb(1, 12'h004, 0);
		chk("cirq", 0, cmd_irq);
		finish_test;
	end
endmodule
